/* File: src/upp_pkg.sv */
// What this block does
// - after power-on reset mode, target, state, enable, pin and alert registers return to default; host access is ready.
// - forward only while input is ok; reverse only while battery is above 3V.
// - reset pulse when one bias supply rises while the other is still low.
// - battery alone: host access and reverse start allowed, bias regulator off.
// - battery alone still keeps the monitoring converter usable.
// - input-good driven low when input is ok and inside its window.
// - valid input and conversion enabled: bias regulator first, then converter.
// - undervolt at regulation level regulates input; below reference stops and releases.
// - overvolt above reference stops the converter and releases input-good.
// - overvolt entry qualified for 100 us, exit for 12 ms.
// - undervolt entry qualified for 100 us, recovery for 12 ms.
// - mode pin sensed once after power-on reset, latched, then ignored.
// - mode resistance at or below 3 kilohm selects buck-boost, auto inductance.
// - higher resistances select buck-only, seven inductor codes 3.3 to 15 uH.
// - forward switching only while the external enable pin is held low.
// - status and input-good pins, and the enable pin, may be host indicators.
// - alert pin pulses low at once on any status change, faults included.
// - converter stops while the thermal shutdown flag is set.
// - output voltage target defaults to 5V after reset, host may change it.
//
// Purpose: shared constants and types of the power-up mode sequencer
// Assumes: 125 MHz reference clock
// Notes:   cycle counts are derived from the printed times
package upp_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_HZ = 125_000_000;
   localparam int DGL_ENTRY_US = 100;
   localparam int DGL_EXIT_MS = 12;
   localparam int DGL_ENTRY_CYC = DGL_ENTRY_US * (CLK_HZ / 1_000_000);
   localparam int DGL_EXIT_CYC = DGL_EXIT_MS * (CLK_HZ / 1_000);
   localparam int BIAS_SETTLE_NS = 1000;
   localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_NS / (1_000_000_000 / CLK_HZ);
   localparam int ALERT_PULSE_NS = 2000;
   localparam int ALERT_PULSE_CYC = ALERT_PULSE_NS / (1_000_000_000 / CLK_HZ);
   localparam logic [2:0] MODE_SENSE_CYC = 3'h4;
   // ==========================================================
   // reset values and encodings
   localparam logic [15:0] VOUT_DEFAULT_MV = 16'h1388;
   localparam logic [2:0] MODE_CODE_BUCK_BOOST = 3'h0;
   localparam int STATUS_W = 7;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_BIAS = 3'b010,
      ST_RUN = 3'b100
   } upp_state_t;
endpackage

/* File: src/upp_filter.sv */
// Purpose: three-flop synchroniser with asymmetric qualification time
// Assumes: input is asynchronous to ref_clk_i
// Notes:   for W above one both times should be 1; bit 0 picks the time
`timescale 1ns/100ps
module upp_filter #(
   parameter int W = 1,
   parameter int ENTRY_CYC = 1,
   parameter int EXIT_CYC = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // raw and qualified level
   input wire logic [W-1:0] raw_i,
   output logic [W-1:0] clean_o
);
   logic [W-1:0] meta;
   logic [W-1:0] sync2;
   logic [W-1:0] sync3;
   logic [20:0] cnt;
   logic [20:0] thr;

   // ==========================================================
   // synchroniser: meta is read by sync2 alone
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         meta <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         meta <= raw_i;
         sync2 <= meta;
         sync3 <= sync2;
      end
   end

   // asserting level uses the entry time, releasing the exit time
   assign thr = sync3[0] ? 21'(ENTRY_CYC) : 21'(EXIT_CYC);

   // ==========================================================
   // a change counts only while sync2 and sync3 agree
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         clean_o <= '0;
         cnt <= 21'h0_0000;
      end else if (sync2 == sync3 && sync3 != clean_o) begin
         if (cnt + 21'h0_0001 >= thr) begin
            clean_o <= sync3;
            cnt <= 21'h0_0000;
         end else begin
            cnt <= cnt + 21'h0_0001;
         end
      end else begin
         cnt <= 21'h0_0000; // any bounce restarts the qualification
      end
   end
endmodule

/* File: src/upp_sequencer.sv */
// Purpose: power-on, mode latch, input window and start-up sequencer
// Assumes: comparator flags and mode code are asynchronous levels
// Notes:   host control bits arrive on ref_clk_i and are not synchronised
`timescale 1ns/100ps
module upp_sequencer import upp_pkg::*; #(
   parameter int OV_ENTRY_CYC = DGL_ENTRY_CYC,
   parameter int OV_EXIT_CYC = DGL_EXIT_CYC,
   parameter int UV_ENTRY_CYC = DGL_ENTRY_CYC,
   parameter int UV_EXIT_CYC = DGL_EXIT_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // supply monitor comparators
   input wire logic input_ok_i,
   input wire logic battery_ok_i,
   input wire logic undervolt_dpm_i,
   input wire logic undervolt_low_i,
   input wire logic overvolt_i,
   input wire logic thermal_shut_i,
   // mode pin resistance decoder
   input wire logic [2:0] mode_code_i,
   // converter-enable pin, two-way
   input wire logic conv_enable_n_i,
   output logic conv_enable_n_o,
   output logic conv_enable_n_oe_n_o,
   // host control bits
   input wire logic conv_allow_i,
   input wire logic reverse_req_i,
   input wire logic gp_status_en_i,
   input wire logic gp_stat_i,
   input wire logic gp_good_i,
   input wire logic gp_ce_en_i,
   input wire logic gp_ce_i,
   input wire logic vout_wr_i,
   input wire logic [15:0] vout_data_i,
   // power stage and system status
   output logic por_o,
   output logic i2c_ready_o,
   output logic adc_enable_o,
   output logic bias_regulator_en_o,
   output logic converter_en_o,
   output logic reverse_en_o,
   output logic input_regulation_o,
   output logic [15:0] output_voltage_target_o,
   // mode result
   output logic mode_valid_o,
   output logic mode_buck_only_o,
   output logic [2:0] inductor_code_o,
   // indicator pins
   output logic input_good_n_o,
   output logic switcher_status_n_o,
   output logic alert_n_o
);
   logic in_ok;
   logic bat_ok;
   logic uv_dpm;
   logic uv_fault;
   logic ov_fault;
   logic hot;
   logic ce_n;
   logic [2:0] mode_code;
   logic in_ok_d;
   logic bat_ok_d;
   logic por_pulse;
   logic soft_rst;
   logic window_ok;
   logic fwd_ok;
   logic [2:0] sense_cnt;
   logic [7:0] bias_cnt;
   logic [7:0] alert_cnt;
   logic [STATUS_W-1:0] status;
   logic [STATUS_W-1:0] status_d;
   upp_state_t state;
   upp_state_t next_state;

   // ==========================================================
   // input conditioning
   upp_filter #(.W(1), .ENTRY_CYC(1), .EXIT_CYC(1)) u_in_ok (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(input_ok_i), .clean_o(in_ok));
   upp_filter #(.W(1), .ENTRY_CYC(1), .EXIT_CYC(1)) u_bat_ok (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(battery_ok_i), .clean_o(bat_ok));
   upp_filter #(.W(1), .ENTRY_CYC(1), .EXIT_CYC(1)) u_dpm (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(undervolt_dpm_i), .clean_o(uv_dpm));
   // rising undervolt flag is the fault entry
   upp_filter #(.W(1), .ENTRY_CYC(UV_ENTRY_CYC),
      .EXIT_CYC(UV_EXIT_CYC)) u_uv (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(undervolt_low_i), .clean_o(uv_fault));
   // rising overvolt entry, long exit
   upp_filter #(.W(1), .ENTRY_CYC(OV_ENTRY_CYC),
      .EXIT_CYC(OV_EXIT_CYC)) u_ov (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(overvolt_i), .clean_o(ov_fault));
   upp_filter #(.W(1), .ENTRY_CYC(1), .EXIT_CYC(1)) u_hot (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(thermal_shut_i), .clean_o(hot));
   // pin idles high, so filter the inverted level to reset low
   upp_filter #(.W(1), .ENTRY_CYC(1), .EXIT_CYC(1)) u_ce (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(~conv_enable_n_i), .clean_o(ce_n));
   upp_filter #(.W(3), .ENTRY_CYC(1), .EXIT_CYC(1)) u_mode (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .raw_i(mode_code_i), .clean_o(mode_code));

   // ==========================================================
   // power-on detection, one supply rising while the other is low
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         in_ok_d <= 1'b0;
         bat_ok_d <= 1'b0;
      end else begin
         in_ok_d <= in_ok;
         bat_ok_d <= bat_ok;
      end
   end
   assign por_pulse = (in_ok && !in_ok_d && !bat_ok) ||
                      (bat_ok && !bat_ok_d && !in_ok);
   // the internal reset restores every default except the filters, the edge flops, por_o, i2c_ready_o and adc_enable_o
   assign soft_rst = reset_i || por_pulse;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         por_o <= 1'b0;
         i2c_ready_o <= 1'b0;
         adc_enable_o <= 1'b0;
      end else begin
         por_o <= por_pulse;
         i2c_ready_o <= !por_pulse && (in_ok || bat_ok);
         adc_enable_o <= in_ok || bat_ok;
      end
   end

   // ==========================================================
   // mode pin: sensed once the synchroniser has settled
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         sense_cnt <= MODE_SENSE_CYC;
         mode_valid_o <= 1'b0;
         mode_buck_only_o <= 1'b0;
         inductor_code_o <= MODE_CODE_BUCK_BOOST;
      end else if (!mode_valid_o) begin
         if (sense_cnt == 3'h0) begin
            mode_valid_o <= 1'b1; // not sensed again until soft_rst
            mode_buck_only_o <= (mode_code != MODE_CODE_BUCK_BOOST);
            inductor_code_o <= mode_code;
         end else begin
            sense_cnt <= sense_cnt - 3'h1;
         end
      end
   end

   // ==========================================================
   // output voltage target, host writable
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         output_voltage_target_o <= VOUT_DEFAULT_MV;
      end else if (vout_wr_i) begin
         output_voltage_target_o <= vout_data_i;
      end
   end

   // ==========================================================
   // forward permission
   assign window_ok = in_ok && !uv_fault && !ov_fault;
   // a pin used as indicator cannot enable switching
   assign fwd_ok = window_ok && conv_allow_i && ce_n && !gp_ce_en_i &&
                   !hot && mode_valid_o;

   // start-up sequence: bias first, converter after settling
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (fwd_ok) begin
               next_state = ST_BIAS;
            end
         end
         ST_BIAS: begin
            if (!fwd_ok) begin
               next_state = ST_OFF;
            end else if (bias_cnt == 8'h00) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!fwd_ok) begin
               next_state = ST_OFF;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   // restart after a stop goes through OFF again
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // bias settle count
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst || state != ST_BIAS) begin
         bias_cnt <= 8'(BIAS_SETTLE_CYC - 1);
      end else if (bias_cnt != 8'h00) begin
         bias_cnt <= bias_cnt - 8'h01;
      end
   end

   // ==========================================================
   // power stage enables, registered
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         bias_regulator_en_o <= 1'b0;
         converter_en_o <= 1'b0;
         reverse_en_o <= 1'b0;
         input_regulation_o <= 1'b0;
      end else begin
         // reverse never lights the bias regulator
         bias_regulator_en_o <= (next_state != ST_OFF);
         converter_en_o <= (next_state == ST_RUN);
         reverse_en_o <= bat_ok && reverse_req_i && !hot &&
                         next_state == ST_OFF;
         input_regulation_o <= uv_dpm && next_state == ST_RUN;
      end
   end

   // ==========================================================
   // indicator pins, optionally owned by the host
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         input_good_n_o <= 1'b1;
         switcher_status_n_o <= 1'b1;
         conv_enable_n_o <= 1'b1;
         conv_enable_n_oe_n_o <= 1'b1;
      end else begin
         input_good_n_o <= gp_status_en_i ? !gp_good_i
                                          : !window_ok;
         switcher_status_n_o <= gp_status_en_i ? !gp_stat_i
            : !(next_state == ST_RUN);
         conv_enable_n_o <= !gp_ce_i;
         conv_enable_n_oe_n_o <= !gp_ce_en_i;
      end
   end

   // ==========================================================
   // alert: any change in status restarts a low pulse
   assign status = {window_ok, state == ST_RUN, reverse_en_o, hot,
                    ov_fault, uv_fault, uv_dpm};
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         status_d <= '0;
      end else begin
         status_d <= status;
      end
   end
   // pulse starts one cycle after the change, no qualification
   always_ff @(posedge ref_clk_i) begin
      if (soft_rst) begin
         alert_cnt <= 8'h00;
         alert_n_o <= 1'b1;
      end else if (status != status_d) begin
         alert_cnt <= 8'(ALERT_PULSE_CYC - 1);
         alert_n_o <= 1'b0;
      end else if (alert_cnt != 8'h00) begin
         alert_cnt <= alert_cnt - 8'h01;
      end else begin
         alert_n_o <= 1'b1;
      end
   end

   // ==========================================================
   // assertions
   sequence s_start;
      state == ST_OFF ##1 state == ST_BIAS;
   endsequence

   a_bias_first_run: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) $rose(converter_en_o) |->
      $past(bias_regulator_en_o))
      else $error("converter started without bias regulator");
   // two quiet cycles catch a settle count that was skipped
   a_start_order_hold: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) s_start |-> !converter_en_o [*2])
      else $error("converter enabled too early");
   a_good_window: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) !gp_status_en_i && window_ok |=>
      !input_good_n_o)
      else $error("input good not low in window");
   a_ov_stop_conv: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) $rose(ov_fault) |=>
      !converter_en_o && !bias_regulator_en_o)
      else $error("converter kept running on overvolt");
   a_uv_stop_conv: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) uv_fault |=> !converter_en_o)
      else $error("converter kept running on undervolt");
   a_hot_stop_conv: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) hot |=> !converter_en_o && !reverse_en_o)
      else $error("converter running in thermal shutdown");
   a_ce_gates_fwd: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) !ce_n |=> !converter_en_o)
      else $error("forward switching without enable pin");
   a_rev_needs_bat: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) reverse_en_o |-> $past(bat_ok))
      else $error("reverse enabled without battery");
   a_rev_no_bias: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) !in_ok |=> !bias_regulator_en_o)
      else $error("bias regulator on from battery alone");
   a_alert_on_change: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) status != status_d |=> !alert_n_o)
      else $error("alert not pulsed on status change");
   a_mode_latch_hold: assert property (@(posedge ref_clk_i)
      disable iff (soft_rst) mode_valid_o |=>
      $stable(inductor_code_o) && mode_valid_o)
      else $error("mode changed after latch");
   a_vout_default: assert property (@(posedge ref_clk_i)
      $past(soft_rst) && !soft_rst |->
      output_voltage_target_o == VOUT_DEFAULT_MV)
      else $error("output target not at default after reset");
endmodule

/* File: bench/upp_analog_model.sv */
// Purpose: far-side model of the converter-enable pin
// Assumes: pin has a pull-up; the external party sinks it to enable
// Notes:   wired-and, so a released pin reads high, never the last value
`timescale 1ns/100ps
module upp_analog_model (
   // external party request and module drive
   input wire logic ext_enable_i,
   input wire logic dev_drive_i,
   input wire logic dev_drive_oe_n_i,
   // resolved pin level
   output logic pin_o
);
   // ==========================================================
   // pin resolution
   // pull-up wins unless someone sinks the line
   always_comb begin
      pin_o = 1'b1;
      if (ext_enable_i) begin
         pin_o = 1'b0;
      end
      if (!dev_drive_oe_n_i && !dev_drive_i) begin
         pin_o = 1'b0;
      end
   end
endmodule

/* File: bench/tb.sv */
// Purpose: self-checking bench of the power-up mode sequencer
// Assumes: filters shortened to 5 entry and 20 exit cycles
// Notes:   wait_bias and wait_por poll with a bound; other waits are fixed by the hand-over latencies, with margin
`timescale 1ns/100ps
module tb;
   logic clk, rst, iok, bok, uvd, uvl, ov, hot, ext, allow, rev;
   logic gse, gst, ggd, gce, gcv, vwr, pin, ce_o, ce_oe_n;
   logic por, rdy, adc, bias, cen, reven, inreg, mval, bonly;
   logic ign, stn, alrt;
   logic [2:0] mode, ind;
   logic [15:0] vdat, tgt;
   int fail_count, samples_checked, n;
   // ==========================================================
   // clock, 8 ns period
   always #4 clk = ~clk;
   upp_analog_model upp_analog_model_inst (.ext_enable_i(ext),
      .dev_drive_i(ce_o), .dev_drive_oe_n_i(ce_oe_n), .pin_o(pin));
   upp_sequencer #(.OV_ENTRY_CYC(5), .OV_EXIT_CYC(20),
      .UV_ENTRY_CYC(5), .UV_EXIT_CYC(20)) upp_sequencer_inst (
      .ref_clk_i(clk), .reset_i(rst), .input_ok_i(iok),
      .battery_ok_i(bok), .undervolt_dpm_i(uvd), .undervolt_low_i(uvl),
      .overvolt_i(ov), .thermal_shut_i(hot), .mode_code_i(mode),
      .conv_enable_n_i(pin), .conv_enable_n_o(ce_o),
      .conv_enable_n_oe_n_o(ce_oe_n), .conv_allow_i(allow),
      .reverse_req_i(rev), .gp_status_en_i(gse), .gp_stat_i(gst),
      .gp_good_i(ggd), .gp_ce_en_i(gce), .gp_ce_i(gcv),
      .vout_wr_i(vwr), .vout_data_i(vdat), .por_o(por),
      .i2c_ready_o(rdy), .adc_enable_o(adc), .bias_regulator_en_o(bias),
      .converter_en_o(cen), .reverse_en_o(reven),
      .input_regulation_o(inreg), .output_voltage_target_o(tgt),
      .mode_valid_o(mval), .mode_buck_only_o(bonly),
      .inductor_code_o(ind), .input_good_n_o(ign),
      .switcher_status_n_o(stn), .alert_n_o(alrt));
   // ==========================================================
   // shared tasks
   // inputs move 1 ns after the edge so the sample is never racy
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_bias();
      for (n = 0; n < 60 && bias !== 1'b1; n++) step(1);
   endtask
   task automatic wait_por();
      for (n = 0; n < 20 && por !== 1'b1; n++) step(1);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // watchdog, far beyond the roughly 1400 cycles the tests need
   initial begin
      #(8 * 20000);
      fail_count++;
      tally_and_finish();
   end
   // ==========================================================
   // main sequence
   initial begin
      clk = 0; rst = 1; iok = 0; bok = 0; uvd = 0; uvl = 0; ov = 0;
      hot = 0; ext = 0; allow = 0; rev = 0; gse = 0; gst = 0; ggd = 0;
      gce = 0; gcv = 0; vwr = 0; vdat = 16'h0000; mode = 3'h6;
      fail_count = 0; samples_checked = 0;
      step(10);
      rst = 0;
      step(2);
      check(tgt, 16'h1388);
      check(ign, 1'b1);
      check(cen, 1'b0);
      vdat = 16'h2ee0;
      vwr = 1;
      step(1);
      vwr = 0;
      step(1);
      check(tgt, 16'h2ee0);
      // power-on from the input supply, battery absent
      iok = 1;
      wait_por();
      check(por, 1'b1);
      step(20);
      check(tgt, 16'h1388);
      check(rdy, 1'b1);
      check(mval, 1'b1);
      check(bonly, 1'b1);
      check(ind, 3'h6);
      mode = 3'h2;
      step(20);
      check(ind, 3'h6);
      $display("test power-on done");
      // start-up order
      ext = 1;
      allow = 1;
      wait_bias();
      check(bias, 1'b1);
      check(cen, 1'b0);
      check(ign, 1'b0);
      step(100);
      check(cen, 1'b0);
      step(40);
      check(cen, 1'b1);
      check(stn, 1'b0);
      $display("test start-up done");
      // overvoltage entry and exit qualification
      ov = 1;
      step(4);
      check(cen, 1'b1);
      step(12);
      check(cen, 1'b0);
      check(ign, 1'b1);
      check(alrt, 1'b0);
      ov = 0;
      step(10);
      check(ign, 1'b1);
      step(300);
      check(ign, 1'b0);
      check(cen, 1'b1);
      $display("test overvoltage done");
      // undervoltage regulation, stop, recovery with conversion off
      uvd = 1;
      step(10);
      check(inreg, 1'b1);
      uvl = 1;
      step(4);
      check(cen, 1'b1);
      step(12);
      check(cen, 1'b0);
      check(ign, 1'b1);
      allow = 0;
      uvl = 0;
      uvd = 0;
      step(10);
      check(ign, 1'b1);
      step(30);
      check(ign, 1'b0);
      check(bias, 1'b0);
      allow = 1;
      wait_bias();
      step(140);
      check(cen, 1'b1);
      $display("test undervoltage done");
      // thermal stop, then external enable released
      hot = 1;
      step(10);
      check(cen, 1'b0);
      hot = 0;
      wait_bias();
      step(140);
      check(cen, 1'b1);
      ext = 0;
      step(10);
      check(cen, 1'b0);
      check(bias, 1'b0);
      $display("test thermal done");
      // host-owned indicators
      gse = 1;
      gst = 1;
      step(3);
      check(ign, 1'b1);
      check(stn, 1'b0);
      gce = 1;
      gcv = 1;
      step(3);
      check(pin, 1'b0);
      ggd = 1;
      step(2);
      check(ign, 1'b0);
      // release the drive first: the echo of our own low on the pin
      // must drain through the synchroniser while indicator use blocks
      gcv = 0;
      step(8);
      check(bias, 1'b0);
      gce = 0;
      gse = 0;
      gst = 0;
      ggd = 0;
      step(400);
      check(alrt, 1'b1);
      $display("test indicators done");
      // battery only power-on
      rst = 1;
      iok = 0;
      mode = 3'h0;
      step(10);
      rst = 0;
      step(5);
      bok = 1;
      wait_por();
      check(por, 1'b1);
      step(20);
      check(rdy, 1'b1);
      check(adc, 1'b1);
      check(bias, 1'b0);
      check(mval, 1'b1);
      check(bonly, 1'b0);
      rev = 1;
      ext = 1;
      allow = 1;
      step(20);
      check(reven, 1'b1);
      check(cen, 1'b0);
      check(bias, 1'b0);
      $display("test battery only done");
      tally_and_finish();
   end
endmodule
